// ==== design/mode_ctrl_pkg.sv ====
package mode_ctrl_pkg;
   localparam int          T_CLK_NS     = 4;
   localparam longint      T_BLINK_MS   = 250;
   localparam longint      T_MIN_RUN_MS = 3000;
   localparam longint      T_SEL_HOLD_MS = 3000;
   localparam longint      T_WDOG_MS    = 100;
   localparam longint      T_TICK_MS    = 1;
   localparam longint      NS_PER_MS    = 1000000;
   localparam int unsigned BLINK_CYC    = int'(T_BLINK_MS * NS_PER_MS / T_CLK_NS);
   localparam int unsigned MIN_RUN_CYC  = int'(T_MIN_RUN_MS * NS_PER_MS / T_CLK_NS);
   localparam int unsigned SEL_HOLD_CYC = int'(T_SEL_HOLD_MS * NS_PER_MS / T_CLK_NS);
   localparam int unsigned WDOG_CYC     = int'(T_WDOG_MS * NS_PER_MS / T_CLK_NS);
   localparam int unsigned TICK_CYC     = int'(T_TICK_MS * NS_PER_MS / T_CLK_NS);

   localparam logic [4:0]  A_CTRL    = 5'h00;
   localparam logic [4:0]  A_CMD     = 5'h04;
   localparam logic [4:0]  A_BKPT    = 5'h08;
   localparam logic [4:0]  A_CYCLIM  = 5'h0C;
   localparam logic [4:0]  A_SUBST   = 5'h10;
   localparam logic [4:0]  A_STATION = 5'h14;
   localparam logic [4:0]  A_STATUS  = 5'h18;

   localparam int          CMD_ERASE   = 0;
   localparam int          CMD_FACTORY = 1;
   localparam int          CMD_STEP    = 2;
   localparam int          CMD_RESUME  = 3;
   localparam int          ST_FAULT    = 8;

   localparam logic [1:0]  CTRL_RST    = 2'h1;
   localparam logic [15:0] CYCLIM_RST  = 16'h0096;
   localparam logic [15:0] CYCLIM_MIN  = 16'h0001;
   localparam logic [6:0]  STATION_DEF = 7'h02;
   localparam logic [1:0]  BKPT_MAX    = 2'h3;
   localparam logic [1:0]  BKPT_STEP   = 2'h2;

   localparam logic [1:0]  AO_VOLT     = 2'h0;
   localparam logic [1:0]  AO_I0_20    = 2'h1;
   localparam logic [1:0]  AO_I4_20    = 2'h2;
   localparam logic [15:0] AO_ZERO     = 16'h0000;
   localparam logic [15:0] AO_4MA      = 16'h1000;

   typedef enum logic [3:0] {
      M_STOP  = 4'h1,
      M_START = 4'h2,
      M_RUN   = 4'h4,
      M_HOLD  = 4'h8
   } mode_t;

   typedef enum logic [6:0] {
      PH_IDLE  = 7'h01,
      PH_CLRIN = 7'h02,
      PH_BOOT  = 7'h04,
      PH_CLROUT = 7'h08,
      PH_READ  = 7'h10,
      PH_MAIN  = 7'h20,
      PH_WRITE = 7'h40
   } phase_t;

   typedef enum logic [6:0] {
      E_IDLE   = 7'h01,
      E_HOLD   = 7'h02,
      E_ARMED  = 7'h04,
      E_WAIT   = 7'h08,
      E_TIP    = 7'h10,
      E_ERASE  = 7'h20,
      E_RELOAD = 7'h40
   } erase_t;
endpackage : mode_ctrl_pkg

// ==== design/mode_ctrl.sv ====
// Notes on behaviour
// - Exactly one of stop, start-up, run or hold is always active.
// - Stop: no program, outputs inhibited, stop indicator on; run indicator off once the 3 s start-up blink time has run out.
// - Entering stop keeps counters, timers, flags and images untouched.
// - Stop to run calls start-up routine, unsupervised, outputs inhibited.
// - Start-up blinks run indicator at least 3 s, stop indicator off.
// - Start-up finished without error moves to run automatically.
// - Run repeats main routine and refreshes the images every cycle.
// - Run releases output inhibit; run indicator on, stop indicator off.
// - Up to 3 breakpoints; reaching one in run enters hold.
// - Hold: run blinks, stop on, code halted, outputs inhibited.
// - Single step is refused when more than 2 breakpoints are defined.
// - 100 ms watchdog and cycle limit (min 1 ms) force a defined stop.
// - Inhibited analog outputs give 0 V, 0 mA or 4 mA, or substitutes.
// - Clear input image, start-up routine, release inhibit, clear output image.
// - Each cycle reads inputs, runs main routine, then writes outputs.
// - Erase clears working memory only, never the memory card.
// - Erase starts only in stop.
// - Selector held in erase position 3 s turns stop blink to steady.
// - Armed: stop, erase, stop within 3 s starts erase; blink until done.
// - After erase, reload default project from card with card indicator on.
// - Factory reset erases everything and sets station address to 2.
// - Differing firmware package in stop after power-on blinks; install on request.
`timescale 1ns/10ps
module mode_ctrl
   import mode_ctrl_pkg::*;
#(
   parameter int unsigned BLINK_CYCLES = BLINK_CYC,
   parameter int unsigned MIN_RUN_CYCLES = MIN_RUN_CYC,
   parameter int unsigned SEL_HOLD_CYCLES = SEL_HOLD_CYC,
   parameter int unsigned WDOG_CYCLES = WDOG_CYC,
   parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        sel_run_pin,
   input  wire logic        sel_erase_pin,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        startup_done,
   input  wire logic        startup_error,
   input  wire logic        main_done,
   input  wire logic        breakpoint_hit,
   input  wire logic        card_has_project,
   input  wire logic        erase_done,
   input  wire logic        reload_done,
   input  wire logic        package_differs,
   input  wire logic [1:0]  ao_range,
   input  wire logic [15:0] ao_app_value,
   output logic      [3:0]  mode,
   output logic             output_inhibit,
   output logic             run_led,
   output logic             stop_led,
   output logic             card_led,
   output logic             system_fault_indicator,
   output logic             input_image_clear,
   output logic             startup_routine,
   output logic             output_image_clear,
   output logic             input_capture,
   output logic             main_cycle_routine,
   output logic             output_write,
   output logic             step_pulse,
   output logic             memory_erase,
   output logic             project_reload,
   output logic             firmware_install,
   output logic      [6:0]  station_addr,
   output logic      [15:0] ao_code
);
   mode_t        mode_q;
   phase_t       phase_q;
   erase_t       erase_q;
   logic [1:0]   sync1_q, sync2_q, sync3_q, sel_q;
   logic [1:0]   ctrl_q, bkpt_q;
   logic [15:0]  cyclim_q, subst_q, cyc_ms_q, ao_q;
   logic [6:0]   station_q;
   logic [31:0]  blink_cnt_q, min_run_q, sel_cnt_q, wdog_q, tick_q, rdata_q;
   logic         blink_q, fault_q, fw_pend_q, boot_q, factory_q;
   logic         run_req, stop_idle, step_ok, viol, cmd_wr;

   assign cmd_wr  = reg_wr && reg_addr == A_CMD;
   assign step_ok = bkpt_q <= BKPT_STEP;
   assign stop_idle = erase_q == E_IDLE && !fw_pend_q;
   assign run_req = sel_q[0] && !sel_q[1] && ctrl_q[0] && stop_idle;

   // Selector pins: a change counts once stages two and three agree.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         sel_q   <= 2'h0;
      end
      else
      begin
         sync1_q <= {sel_erase_pin, sel_run_pin};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q)
            sel_q <= sync3_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b || blink_cnt_q >= BLINK_CYCLES - 1)
         blink_cnt_q <= 32'h0;
      else
         blink_cnt_q <= blink_cnt_q + 32'h1;
      if (!rst_b)
         blink_q <= 1'b0;
      else if (blink_cnt_q >= BLINK_CYCLES - 1)
         blink_q <= !blink_q;
   end

   // Register writes; command bits are one-shot and are not stored.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         ctrl_q    <= CTRL_RST;
         bkpt_q    <= 2'h0;
         cyclim_q  <= CYCLIM_RST;
         subst_q   <= AO_ZERO;
         station_q <= STATION_DEF;
      end
      else
      begin
         if (reg_wr && reg_addr == A_CTRL)
            ctrl_q <= reg_wdata[1:0];
         if (reg_wr && reg_addr == A_BKPT)
            bkpt_q <= (reg_wdata > 32'(BKPT_MAX)) ? BKPT_MAX : reg_wdata[1:0];
         if (reg_wr && reg_addr == A_CYCLIM)
            cyclim_q <= (reg_wdata[15:0] < CYCLIM_MIN) ? CYCLIM_MIN : reg_wdata[15:0];
         if (reg_wr && reg_addr == A_SUBST)
            subst_q <= reg_wdata[15:0];
         if (erase_q == E_ERASE && erase_done && factory_q)
            station_q <= STATION_DEF;
         else if (reg_wr && reg_addr == A_STATION)
            station_q <= reg_wdata[6:0];
      end
   end

   // Read data stand in the cycle after the read strobe only.
   always_ff @(posedge clock)
   begin
      if (!rst_b || !reg_rd)
         rdata_q <= 32'h0;
      else if (reg_addr == A_CTRL)
         rdata_q <= {30'h0, ctrl_q};
      else if (reg_addr == A_BKPT)
         rdata_q <= {30'h0, bkpt_q};
      else if (reg_addr == A_CYCLIM)
         rdata_q <= {16'h0, cyclim_q};
      else if (reg_addr == A_SUBST)
         rdata_q <= {16'h0, subst_q};
      else if (reg_addr == A_STATION)
         rdata_q <= {25'h0, station_q};
      else if (reg_addr == A_STATUS)
         rdata_q <= {20'h0, step_ok, fw_pend_q, erase_q == E_IDLE, fault_q, 4'h0, mode_q};
      else
         rdata_q <= 32'h0;
   end

   // supervision over run cycles only, never during start-up
   always_ff @(posedge clock)
   begin
      if (!rst_b || phase_q == PH_READ || mode_q != M_RUN)
      begin
         wdog_q   <= 32'h0;
         tick_q   <= 32'h0;
         cyc_ms_q <= 16'h0;
      end
      else
      begin
         wdog_q <= wdog_q + 32'h1;
         if (tick_q >= TICK_CYCLES - 1)
         begin
            tick_q   <= 32'h0;
            cyc_ms_q <= cyc_ms_q + 16'h1;
         end
         else
            tick_q <= tick_q + 32'h1;
      end
   end
   assign viol = mode_q == M_RUN && (wdog_q >= WDOG_CYCLES || cyc_ms_q > cyclim_q);

   // Fault flag: a new violation wins over a software clear.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         fault_q <= 1'b0;
      else if (viol || (mode_q == M_START && startup_error))
         fault_q <= 1'b1;
      else if (reg_wr && reg_addr == A_STATUS && reg_wdata[ST_FAULT])
         fault_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         mode_q  <= M_STOP;
         phase_q <= PH_IDLE;
      end
      else
      begin
         case (mode_q)
            M_STOP:
            begin
               // no image clear on entering stop
               phase_q <= PH_IDLE;
               if (run_req)
               begin
                  mode_q  <= M_START;
                  phase_q <= PH_CLRIN;
               end
            end
            M_START:
            begin
               if (!run_req || startup_error)
               begin
                  mode_q  <= M_STOP;
                  phase_q <= PH_IDLE;
               end
               else if (phase_q == PH_CLRIN)
                  phase_q <= PH_BOOT;
               else if (startup_done)
               begin
                  mode_q  <= M_RUN;
                  phase_q <= PH_CLROUT;
               end
            end
            M_RUN:
            begin
               if (!run_req || viol)
               begin
                  mode_q  <= M_STOP;
                  phase_q <= PH_IDLE;
               end
               else if (phase_q == PH_MAIN && breakpoint_hit && bkpt_q != 2'h0)
                  mode_q <= M_HOLD;
               else
               begin
                  case (phase_q)
                     PH_CLROUT: phase_q <= PH_READ;
                     PH_READ:   phase_q <= PH_MAIN;
                     PH_MAIN:   phase_q <= main_done ? PH_WRITE : PH_MAIN;
                     default:   phase_q <= PH_READ;
                  endcase
               end
            end
            default:
            begin
               if (!run_req)
               begin
                  mode_q  <= M_STOP;
                  phase_q <= PH_IDLE;
               end
               else if (cmd_wr && reg_wdata[CMD_RESUME])
                  mode_q <= M_RUN;
            end
         endcase
      end
   end

   // step only from hold with at most two breakpoints
   assign step_pulse = mode_q == M_HOLD && cmd_wr && reg_wdata[CMD_STEP] && step_ok;

   // run indicator blinks at least the minimum start-up time
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         min_run_q <= 32'h0;
      else if (mode_q == M_STOP && run_req)
         min_run_q <= MIN_RUN_CYCLES - 1;
      else if (min_run_q != 32'h0)
         min_run_q <= min_run_q - 32'h1;
   end

   // selector erase sequence, stop mode only
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         erase_q   <= E_IDLE;
         sel_cnt_q <= 32'h0;
         factory_q <= 1'b0;
      end
      else
      begin
         sel_cnt_q <= sel_cnt_q + 32'h1;
         case (erase_q)
            E_IDLE:
            begin
               sel_cnt_q <= 32'h0;
               factory_q <= cmd_wr && reg_wdata[CMD_FACTORY];
               if (mode_q == M_STOP && !fw_pend_q)
               begin
                  if (cmd_wr && (reg_wdata[CMD_ERASE] || reg_wdata[CMD_FACTORY]))
                     erase_q <= E_ERASE;
                  else if (sel_q[1])
                     erase_q <= E_HOLD;
               end
            end
            E_HOLD:
               if (!sel_q[1])
                  erase_q <= E_IDLE;
               else if (sel_cnt_q >= SEL_HOLD_CYCLES - 1)
                  erase_q <= E_ARMED;
            E_ARMED:
               if (!sel_q[1])
                  erase_q <= E_WAIT;
            E_WAIT:
            begin
               sel_cnt_q <= 32'h0;
               if (sel_q[1])
                  erase_q <= E_TIP;
               else if (sel_q[0])
                  erase_q <= E_IDLE;
            end
            E_TIP:
               if (sel_cnt_q >= SEL_HOLD_CYCLES - 1)
                  erase_q <= E_IDLE;
               else if (!sel_q[1])
                  erase_q <= E_ERASE;
            E_ERASE:
               if (erase_done)
                  erase_q <= card_has_project ? E_RELOAD : E_IDLE;
            default:
               if (reload_done)
                  erase_q <= E_IDLE;
         endcase
      end
   end

   // firmware package check after power-on in stop
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         boot_q    <= 1'b1;
         fw_pend_q <= 1'b0;
      end
      else
      begin
         boot_q <= 1'b0;
         if (boot_q && !sel_q[0] && package_differs)
            fw_pend_q <= 1'b1;
         else if (fw_pend_q && sel_q[1])
            fw_pend_q <= 1'b0;
      end
   end
   assign firmware_install = fw_pend_q && sel_q[1];

   // inhibited analog value by range or substitute
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         ao_q <= AO_ZERO;
      else if (mode_q == M_RUN)
         ao_q <= ao_app_value;
      else if (ctrl_q[1])
         ao_q <= subst_q;
      else if (ao_range == AO_I4_20)
         ao_q <= AO_4MA;
      else
         ao_q <= AO_ZERO;
   end

   assign mode               = mode_q;
   assign output_inhibit     = mode_q != M_RUN;
   assign run_led            = (mode_q == M_RUN && min_run_q == 32'h0) ||
                               ((mode_q == M_START || mode_q == M_HOLD ||
                                 min_run_q != 32'h0) && blink_q);
   assign stop_led           = mode_q == M_START ? 1'b0 :
                               mode_q == M_RUN ? 1'b0 :
                               (erase_q == E_HOLD || erase_q == E_ERASE) ? blink_q : 1'b1;
   assign card_led           = erase_q == E_RELOAD;
   assign system_fault_indicator = fault_q || (fw_pend_q && blink_q);
   assign input_image_clear  = phase_q == PH_CLRIN;
   assign startup_routine    = mode_q == M_START && phase_q == PH_BOOT;
   assign output_image_clear = mode_q == M_RUN && phase_q == PH_CLROUT;
   assign input_capture      = mode_q == M_RUN && phase_q == PH_READ;
   assign main_cycle_routine = mode_q == M_RUN && phase_q == PH_MAIN;
   assign output_write       = mode_q == M_RUN && phase_q == PH_WRITE;
   assign memory_erase       = erase_q == E_ERASE;
   assign project_reload     = erase_q == E_RELOAD;
   assign station_addr       = station_q;
   assign ao_code            = ao_q;
   assign reg_rdata          = rdata_q;

   AST_ONE_MODE: assert property (@(posedge clock) disable iff (!rst_b)
      $onehot(mode_q)) else $error("mode not one-hot");
   AST_STOP_OUT: assert property (@(posedge clock) disable iff (!rst_b)
      mode_q == M_STOP && erase_q == E_IDLE && min_run_q == 32'h0
      |-> output_inhibit && !run_led && stop_led && !main_cycle_routine)
      else $error("stop outputs wrong");
   AST_BOOT_INH: assert property (@(posedge clock) disable iff (!rst_b)
      startup_routine |-> output_inhibit && !stop_led && $past(phase_q) != PH_IDLE)
      else $error("start-up not inhibited");
   AST_MIN_BLINK: assert property (@(posedge clock) disable iff (!rst_b)
      mode_q == M_START && $past(mode_q) == M_STOP |-> min_run_q == MIN_RUN_CYCLES - 1)
      else $error("blink time not loaded");
   AST_RUN_OUT: assert property (@(posedge clock) disable iff (!rst_b)
      mode_q == M_RUN && min_run_q == 32'h0 |-> !output_inhibit && run_led && !stop_led)
      else $error("run outputs wrong");
   AST_HOLD_OUT: assert property (@(posedge clock) disable iff (!rst_b)
      mode_q == M_HOLD |-> output_inhibit && stop_led && !main_cycle_routine)
      else $error("hold outputs wrong");
   AST_STEP_REF: assert property (@(posedge clock) disable iff (!rst_b)
      step_pulse |-> bkpt_q <= 2'h2 && mode_q == M_HOLD) else $error("step not refused");
   AST_CYCLE_ORD: assert property (@(posedge clock) disable iff (!rst_b)
      input_capture && !viol && run_req |=> main_cycle_routine || mode_q == M_HOLD)
      else $error("main routine did not follow input capture");
   AST_ERASE_STOP: assert property (@(posedge clock) disable iff (!rst_b)
      memory_erase |-> mode_q == M_STOP) else $error("erase outside stop");
endmodule : mode_ctrl

// ==== sim/io_partner.sv ====
`timescale 1ns/10ps
module io_partner
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       startup_routine,
   input  wire logic       main_cycle_routine,
   input  wire logic       memory_erase,
   input  wire logic       project_reload,
   input  wire logic [8:0] lat_boot,
   input  wire logic [8:0] lat,
   input  wire logic       stall,
   output logic            startup_done,
   output logic            main_done,
   output logic            erase_done,
   output logic            reload_done
);
   logic [3:0] phase_q;
   logic [8:0] cnt_q;
   wire  [3:0] phase = {startup_routine, main_cycle_routine, memory_erase, project_reload};

   // The count restarts whenever the device moves to another phase.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         phase_q      <= 4'h0;
         cnt_q        <= 9'h000;
         startup_done <= 1'b0;
         main_done    <= 1'b0;
         erase_done   <= 1'b0;
         reload_done  <= 1'b0;
      end
      else
      begin
         phase_q      <= phase;
         cnt_q        <= (phase != phase_q) ? 9'h000 : cnt_q + 9'h001;
         startup_done <= startup_routine && cnt_q == lat_boot;
         main_done    <= main_cycle_routine && !stall && cnt_q == lat;
         erase_done   <= memory_erase && cnt_q == lat;
         reload_done  <= project_reload && cnt_q == lat;
      end
   end
endmodule : io_partner

// ==== sim/test_plc_operating_mode_controller.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module test_plc_operating_mode_controller;
   import mode_ctrl_pkg::*;
   logic        clock = 1'b0, rst_b = 1'b0, sel_run_pin = 1'b0, sel_erase_pin = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, breakpoint_hit = 1'b0, card_has_project = 1'b0;
   logic        package_differs = 1'b0, stall = 1'b0, startup_error = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [1:0]  ao_range = 2'h0;
   logic [15:0] ao_app_value = 16'h1234, ao_code;
   logic [8:0]  lat_boot = 9'h0FA, lat = 9'h003;
   logic [3:0]  mode;
   logic [6:0]  station_addr;
   logic        startup_done, main_done, erase_done, reload_done, output_inhibit, run_led;
   logic        stop_led, card_led, system_fault_indicator, input_image_clear, startup_routine;
   logic        output_image_clear, input_capture, main_cycle_routine, output_write, step_pulse;
   logic        memory_erase, project_reload, firmware_install;
   int          fail_count = 0, n_compared = 0;
   wire  [5:0]  obs = {firmware_install, project_reload, memory_erase, output_write,
                       startup_routine, input_image_clear};

   mode_ctrl #(.BLINK_CYCLES(4), .MIN_RUN_CYCLES(40), .SEL_HOLD_CYCLES(30),
      .WDOG_CYCLES(200), .TICK_CYCLES(10)) u_dut (.clock, .rst_b, .sel_run_pin,
      .sel_erase_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .startup_done,
      .startup_error, .main_done, .breakpoint_hit, .card_has_project, .erase_done,
      .reload_done, .package_differs, .ao_range, .ao_app_value, .mode, .output_inhibit,
      .run_led, .stop_led, .card_led, .system_fault_indicator, .input_image_clear,
      .startup_routine, .output_image_clear, .input_capture, .main_cycle_routine,
      .output_write, .step_pulse, .memory_erase, .project_reload, .firmware_install,
      .station_addr, .ao_code);

   io_partner u_partner (.clock, .rst_b, .startup_routine, .main_cycle_routine,
      .memory_erase, .project_reload, .lat_boot, .lat, .stall, .startup_done, .main_done,
      .erase_done, .reload_done);

   initial forever #2 clock = ~clock;

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_mode(input logic [3:0] m);
      for (int i = 0; i < 600 && mode !== m; i++)
         @(posedge clock) #1;
      `CHK("mode", m, mode)
      if (mode !== m)
         report_and_stop();
   endtask : wait_mode

   task automatic wait_obs(input int k);
      for (int i = 0; i < 600 && obs[k] !== 1'b1; i++)
         @(posedge clock) #1;
      `CHK("phase output", 1'b1, obs[k])
      if (obs[k] !== 1'b1)
         report_and_stop();
   endtask : wait_obs

   task automatic step_try(input logic e);
      @(posedge clock);
      reg_addr  <= A_CMD;
      reg_wdata <= 32'h4;
      reg_wr    <= 1'b1;
      #1 `CHK("step_pulse", e, step_pulse)
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : step_try

   task automatic sc_stop_and_limits();
      `CHK("mode", M_STOP, mode)
      `CHK("inhibit", 1'b1, output_inhibit)
      `CHK("stop_led", 1'b1, stop_led)
      `CHK("run_led", 1'b0, run_led)
      rd(A_CYCLIM);
      `CHK("cyclim", CYCLIM_RST, d[15:0])
      wr(A_CYCLIM, 32'h0);
      rd(A_CYCLIM);
      `CHK("cyclim", CYCLIM_MIN, d[15:0])
      wr(A_CYCLIM, 32'h96);
      for (int r = 0; r < 3; r++)
      begin
         @(posedge clock);
         ao_range <= 2'(r);
         repeat (3) @(posedge clock);
         #1 `CHK("ao_code", (r == 2) ? AO_4MA : AO_ZERO, ao_code)
      end
   endtask : sc_stop_and_limits

   task automatic sc_startup();
      @(posedge clock);
      sel_run_pin <= 1'b1;
      wait_obs(0);
      `CHK("mode", M_START, mode)
      `CHK("inhibit", 1'b1, output_inhibit)
      `CHK("stop_led", 1'b0, stop_led)
      wait_obs(1);
      repeat (210) @(posedge clock);
      #1 `CHK("mode", M_START, mode)
      wait_mode(M_RUN);
      `CHK("output_image_clear", 1'b1, output_image_clear)
      `CHK("inhibit", 1'b0, output_inhibit)
      `CHK("run_led", 1'b1, run_led)
      `CHK("stop_led", 1'b0, stop_led)
      wait_obs(2);
      @(posedge clock) #1;
      `CHK("input_capture", 1'b1, input_capture)
      `CHK("ao_code", 16'h1234, ao_code)
      @(posedge clock) #1 `CHK("main routine", 1'b1, main_cycle_routine)
   endtask : sc_startup

   task automatic sc_hold();
      wr(A_CMD, 32'h1);
      repeat (5) @(posedge clock);
      #1 `CHK("memory_erase", 1'b0, memory_erase)
      wr(A_BKPT, 32'h1);
      breakpoint_hit <= 1'b1;
      wait_mode(M_HOLD);
      @(posedge clock);
      breakpoint_hit <= 1'b0;
      #1 `CHK("inhibit", 1'b1, output_inhibit)
      `CHK("stop_led", 1'b1, stop_led)
      step_try(1'b1);
      wr(A_BKPT, 32'h2);
      step_try(1'b1);
      wr(A_BKPT, 32'h7);
      step_try(1'b0);
      rd(A_BKPT);
      `CHK("bkpt", BKPT_MAX, d[1:0])
      wr(A_BKPT, 32'h0);
      wr(A_CMD, 32'h8);
      wait_mode(M_RUN);
   endtask : sc_hold

   task automatic sc_watchdog();
      @(posedge clock);
      stall <= 1'b1;
      wait_mode(M_STOP);
      `CHK("inhibit", 1'b1, output_inhibit)
      @(posedge clock);
      sel_run_pin <= 1'b0;
      stall       <= 1'b0;
      repeat (10) @(posedge clock);
      wait_mode(M_STOP);
      rd(A_STATUS);
      `CHK("fault", 1'b1, d[ST_FAULT])
      `CHK("fault led", 1'b1, system_fault_indicator)
   endtask : sc_watchdog

   task automatic sc_erase();
      @(posedge clock);
      sel_erase_pin <= 1'b1;
      repeat (40) @(posedge clock);
      for (int i = 0; i < 4; i++)
         @(posedge clock) #1 `CHK("stop_led", 1'b1, stop_led)
      @(posedge clock);
      sel_erase_pin    <= 1'b0;
      card_has_project <= 1'b1;
      repeat (6) @(posedge clock);
      sel_erase_pin <= 1'b1;
      repeat (6) @(posedge clock);
      sel_erase_pin <= 1'b0;
      wait_obs(3);
      wait_obs(4);
      `CHK("card_led", 1'b1, card_led)
      repeat (20) @(posedge clock);
      rd(A_STATUS);
      `CHK("erase idle", 1'b1, d[9])
      `CHK("mode", M_STOP, d[3:0])
   endtask : sc_erase

   task automatic sc_factory();
      wr(A_STATION, 32'h5);
      rd(A_STATION);
      `CHK("station", 7'h05, d[6:0])
      @(posedge clock);
      card_has_project <= 1'b0;
      wr(A_CMD, 32'h2);
      wait_obs(3);
      repeat (20) @(posedge clock);
      #1 `CHK("station", STATION_DEF, station_addr)
   endtask : sc_factory

   task automatic sc_firmware();
      int n = 0;
      @(posedge clock);
      package_differs <= 1'b1;
      rst_b           <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      package_differs <= 1'b0;
      rd(A_STATUS);
      `CHK("fw pending", 1'b1, d[10])
      for (int i = 0; i < 8; i++)
         @(posedge clock) #1 n += int'(system_fault_indicator);
      `CHK("fault led blinks", 4, n)
      @(posedge clock);
      sel_erase_pin <= 1'b1;
      wait_obs(5);
      @(posedge clock);
      sel_erase_pin <= 1'b0;
   endtask : sc_firmware

   task automatic sc_boot_error();
      int n = 0;
      @(posedge clock);
      sel_run_pin <= 1'b1;
      wait_obs(1);
      @(posedge clock);
      startup_error <= 1'b1;
      sel_run_pin   <= 1'b0;
      repeat (12) @(posedge clock);
      startup_error <= 1'b0;
      #1 `CHK("mode", M_STOP, mode)
      for (int i = 0; i < 8; i++)
         @(posedge clock) #1 n += int'(run_led);
      `CHK("run_led blinks", 4, n)
      `CHK("fault led", 1'b1, system_fault_indicator)
   endtask : sc_boot_error

   initial
   begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock) #1;
      sc_stop_and_limits();
      sc_startup();
      sc_hold();
      sc_watchdog();
      sc_erase();
      sc_factory();
      sc_firmware();
      sc_boot_error();
      report_and_stop();
   end
endmodule : test_plc_operating_mode_controller
